// ==== eac_map.vh ====
// Constants for the effective address calculation block
`ifndef EAC_MAP_VH
`define EAC_MAP_VH

// ------------------------------------------------------------
// Addressing mode codes
// ------------------------------------------------------------
`define EAC_M_DREG      5'h00
`define EAC_M_AREG      5'h01
`define EAC_M_IND       5'h02
`define EAC_M_POSTINC   5'h03
`define EAC_M_PREDEC    5'h04
`define EAC_M_DISP16    5'h05
`define EAC_M_IDX8      5'h06
`define EAC_M_IDXBD     5'h07
`define EAC_M_MEMPOST   5'h08
`define EAC_M_MEMPRE    5'h09
`define EAC_M_PCDISP16  5'h0a
`define EAC_M_PCIDX8    5'h0b
`define EAC_M_PCIDXBD   5'h0c
`define EAC_M_PCMEMPOST 5'h0d
`define EAC_M_PCMEMPRE  5'h0e
`define EAC_M_ABSW      5'h0f
`define EAC_M_ABSL      5'h10
`define EAC_M_IMM       5'h11

// ------------------------------------------------------------
// Operand size codes
// ------------------------------------------------------------
`define EAC_SZ_BYTE 2'h0
`define EAC_SZ_WORD 2'h1
`define EAC_SZ_LONG 2'h2
`define EAC_SZ_QUAD 2'h3

// ------------------------------------------------------------
// Data type codes
// ------------------------------------------------------------
`define EAC_DT_INT      2'h0
`define EAC_DT_BCD_PACK 2'h1
`define EAC_DT_BCD_UNPK 2'h2
`define EAC_DT_FIELD    2'h3

// ------------------------------------------------------------
// Field limits, reset values and state codes
// ------------------------------------------------------------
`define EAC_FIELD_MIN   6'h01
`define EAC_FIELD_MAX   6'h20
`define EAC_ZERO32      32'h0000_0000
`define EAC_ST_IDLE     2'h0
`define EAC_ST_FETCH    2'h1
`define EAC_ST_DONE     2'h2

`endif

// ==== eac_core.v ====
// Effective address calculation with memory indirection
`timescale 1ns/1ps
`include "eac_map.vh"

// Summary of operation
// - Bit field length accepted from 1 through 32; others flagged illegal.
// - Decimal digits per byte: two when packed (quad size gives a count of 0), one when unpacked.
// - Integer operand sizes byte, word, long word and quad word.
// - Address register indirect: plain, postincrement, predecrement, displacement, indexed.
// - 8 and 16 bit displacements are sign-extended then added.
// - Index is any register, word or long, scaled by 1, 2, 4 or 8.
// - Base displacement is a signed 16 or 32 bit extension value.
// - Outer displacement of 16 or 32 bits added after indirection.
// - Memory indirect modes fetch a long-word pointer used as base.
// - Pre-indexed adds index before fetch, post-indexed after; address or PC base.
// - PC relative offers 16 bit displacement and 8 bit or base displacement indexed forms.
// - Immediate operands are 8, 16 or 32 bits wide.
module eac_core
(
	input  wire        clock,
	input  wire        reset_n,
	input  wire        start,
	input  wire [4:0]  mode,
	input  wire [1:0]  op_size,
	input  wire [1:0]  data_type,
	input  wire [5:0]  field_width,
	input  wire [3:0]  addr_reg_sel,
	input  wire [3:0]  data_reg_sel,
	input  wire [3:0]  index_reg_sel,
	input  wire        index_long,
	input  wire [1:0]  index_scale,
	input  wire [31:0] addr_reg_value,
	input  wire [31:0] index_reg_value,
	input  wire [31:0] pc_value,
	input  wire [15:0] short_disp,
	input  wire [31:0] base_disp,
	input  wire        base_disp_long,
	input  wire        base_disp_present,
	input  wire [31:0] outer_disp,
	input  wire        outer_disp_long,
	input  wire        outer_disp_present,
	input  wire [31:0] ext_value,
	output wire        fetch_req,
	output reg  [31:0] fetch_addr,
	input  wire        fetch_ack,
	input  wire [31:0] fetch_data,
	output wire        busy,
	output reg         done,
	output reg  [31:0] ea,
	output reg  [31:0] imm_value,
	output reg         is_register,
	output reg         is_immediate,
	output reg  [3:0]  reg_sel,
	output reg         reg_write,
	output reg  [3:0]  reg_write_sel,
	output reg  [31:0] reg_write_value,
	output reg  [3:0]  size_bytes,
	output reg  [3:0]  bcd_digits,
	output reg         illegal
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	function [31:0] sext16;
		input [15:0] v;
		begin
			sext16 = {{16{v[15]}}, v};
		end
	endfunction

	function [31:0] sext8;
		input [7:0] v;
		begin
			sext8 = {{24{v[7]}}, v};
		end
	endfunction

	// Index value sized then scaled
	function [31:0] scaled_index;
		input [31:0] v;
		input        lng;
		input [1:0]  sc;
		reg   [31:0] s;
		begin
			s = lng ? v : sext16(v[15:0]);
			scaled_index = s << sc;
		end
	endfunction

	function [3:0] bytes_of;
		input [1:0] sz;
		begin
			case (sz)
				`EAC_SZ_BYTE: bytes_of = 4'h1;
				`EAC_SZ_WORD: bytes_of = 4'h2;
				`EAC_SZ_LONG: bytes_of = 4'h4;
				default:      bytes_of = 4'h8;
			endcase
		end
	endfunction

	function [31:0] disp_sel;
		input [31:0] v;
		input        lng;
		input        present;
		begin
			if (!present)
				disp_sel = `EAC_ZERO32;
			else
				disp_sel = lng ? v : sext16(v[15:0]);
		end
	endfunction

	// ------------------------------------------------------------
	// Combinational address forms
	// ------------------------------------------------------------
	wire [31:0] idx_term = scaled_index(index_reg_value, index_long, index_scale);
	wire [31:0] base_ofs = disp_sel(base_disp, base_disp_long, base_disp_present);
	wire [31:0] outr_ofs = disp_sel(outer_disp, outer_disp_long, outer_disp_present);
	wire [3:0]  sz_bytes = bytes_of(op_size);
	wire        pc_based = (mode == `EAC_M_PCMEMPOST) || (mode == `EAC_M_PCMEMPRE);
	wire        pre_idx  = (mode == `EAC_M_MEMPRE) || (mode == `EAC_M_PCMEMPRE);
	wire [31:0] ind_base = pc_based ? pc_value : addr_reg_value;
	wire        field_ok = (field_width >= `EAC_FIELD_MIN) && (field_width <= `EAC_FIELD_MAX);
	wire        imm_ok   = (op_size != `EAC_SZ_QUAD);

	localparam [1:0] ST_IDLE  = `EAC_ST_IDLE;
	localparam [1:0] ST_FETCH = `EAC_ST_FETCH;

	reg [1:0]  state;
	reg        held_post;

	assign fetch_req = (state == ST_FETCH);
	assign busy      = (state != ST_IDLE);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state           <= ST_IDLE;
			held_post       <= 1'b0;
			fetch_addr      <= `EAC_ZERO32;
			done            <= 1'b0;
			ea              <= `EAC_ZERO32;
			imm_value       <= `EAC_ZERO32;
			is_register     <= 1'b0;
			is_immediate    <= 1'b0;
			reg_sel         <= 4'h0;
			reg_write       <= 1'b0;
			reg_write_sel   <= 4'h0;
			reg_write_value <= `EAC_ZERO32;
			size_bytes      <= 4'h0;
			bcd_digits      <= 4'h0;
			illegal         <= 1'b0;
		end
		else
		begin
			done      <= 1'b0;
			reg_write <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (start)
					begin
						size_bytes   <= sz_bytes;
						is_register  <= 1'b0;
						is_immediate <= 1'b0;
						imm_value    <= `EAC_ZERO32;
						illegal      <= 1'b0;
						reg_sel      <= addr_reg_sel;
						// Packed BCD doubles digit density per byte; quad size wraps the count to 0
						case (data_type)
							`EAC_DT_BCD_PACK: bcd_digits <= {sz_bytes[2:0], 1'b0};
							`EAC_DT_BCD_UNPK: bcd_digits <= sz_bytes;
							default:          bcd_digits <= 4'h0;
						endcase
						if (data_type == `EAC_DT_FIELD && !field_ok)
							illegal <= 1'b1;
						case (mode)
							`EAC_M_DREG:
							begin
								is_register <= 1'b1;
								reg_sel     <= data_reg_sel;
								done        <= 1'b1;
							end
							`EAC_M_AREG:
							begin
								is_register <= 1'b1;
								done        <= 1'b1;
							end
							`EAC_M_IND:
							begin
								ea   <= addr_reg_value;
								done <= 1'b1;
							end
							`EAC_M_POSTINC:
							begin
								ea              <= addr_reg_value;
								reg_write       <= 1'b1;
								reg_write_sel   <= addr_reg_sel;
								reg_write_value <= addr_reg_value + {28'h000_0000, sz_bytes};
								done            <= 1'b1;
							end
							`EAC_M_PREDEC:
							begin
								ea              <= addr_reg_value - {28'h000_0000, sz_bytes};
								reg_write       <= 1'b1;
								reg_write_sel   <= addr_reg_sel;
								reg_write_value <= addr_reg_value - {28'h000_0000, sz_bytes};
								done            <= 1'b1;
							end
							`EAC_M_DISP16:
							begin
								ea   <= addr_reg_value + sext16(short_disp);
								done <= 1'b1;
							end
							`EAC_M_IDX8:
							begin
								ea   <= addr_reg_value + sext8(short_disp[7:0]) + idx_term;
								done <= 1'b1;
							end
							`EAC_M_IDXBD:
							begin
								ea   <= addr_reg_value + base_ofs + idx_term;
								done <= 1'b1;
							end
							`EAC_M_PCDISP16:
							begin
								ea   <= pc_value + sext16(short_disp);
								done <= 1'b1;
							end
							`EAC_M_PCIDX8:
							begin
								ea   <= pc_value + sext8(short_disp[7:0]) + idx_term;
								done <= 1'b1;
							end
							`EAC_M_PCIDXBD:
							begin
								ea   <= pc_value + base_ofs + idx_term;
								done <= 1'b1;
							end
							`EAC_M_MEMPOST, `EAC_M_MEMPRE, `EAC_M_PCMEMPOST, `EAC_M_PCMEMPRE:
							begin
								// Index joins before the fetch only in pre-indexed forms
								fetch_addr <= ind_base + base_ofs
									+ (pre_idx ? idx_term : `EAC_ZERO32);
								held_post  <= !pre_idx;
								state      <= ST_FETCH;
							end
							`EAC_M_ABSW:
							begin
								ea   <= sext16(short_disp);
								done <= 1'b1;
							end
							`EAC_M_ABSL:
							begin
								ea   <= ext_value;
								done <= 1'b1;
							end
							`EAC_M_IMM:
							begin
								is_immediate <= 1'b1;
								// Only set here, so a bad field width stays flagged
								if (!imm_ok)
									illegal <= 1'b1;
								// Byte immediates sit in the low byte of the word
								case (op_size)
									`EAC_SZ_BYTE: imm_value <= {24'h00_0000, ext_value[7:0]};
									`EAC_SZ_WORD: imm_value <= {16'h0000, ext_value[15:0]};
									default:      imm_value <= ext_value;
								endcase
								done <= 1'b1;
							end
							default:
							begin
								illegal <= 1'b1;
								done    <= 1'b1;
							end
						endcase
					end
				end
				ST_FETCH:
				begin
					// Operands from the decoder must stay stable until done
					if (fetch_ack)
					begin
						ea    <= fetch_data + (held_post ? idx_term : `EAC_ZERO32)
							+ outr_ofs;
						done  <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

endmodule

// ==== eac_core_sva.sv ====
// Concurrent checks on the effective address block ports
`timescale 1ns/1ps
`include "eac_map.vh"
module eac_core_sva
(
	input wire        clock,
	input wire        reset_n,
	input wire        start,
	input wire [4:0]  mode,
	input wire [1:0]  op_size,
	input wire [1:0]  data_type,
	input wire [5:0]  field_width,
	input wire [31:0] addr_reg_value,
	input wire [15:0] short_disp,
	input wire        fetch_req,
	input wire        fetch_ack,
	input wire        busy,
	input wire        done,
	input wire [31:0] ea,
	input wire        reg_write,
	input wire [31:0] reg_write_value,
	input wire [3:0]  size_bytes,
	input wire [3:0]  bcd_digits,
	input wire        illegal
);
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
wire       go = start && !busy;
wire       ind = mode == `EAC_M_MEMPOST || mode == `EAC_M_MEMPRE
	|| mode == `EAC_M_PCMEMPOST || mode == `EAC_M_PCMEMPRE;
reg [31:0] sd_ext;
// Registered copy so the check sees the displacement of the request edge
always @(posedge clock)
begin
	sd_ext <= {{16{short_disp[15]}}, short_disp};
end
default clocking @(posedge clock); endclocking
default disable iff (!reset_n);
a_direct_done: assert property (go && !ind |=> done)
	else $error("direct mode gave no done");
a_indirect_fetch: assert property (go && ind |=> fetch_req && busy && !done)
	else $error("indirect mode did not fetch");
a_ack_done: assert property (fetch_req && fetch_ack |=> done && !fetch_req)
	else $error("pointer ack did not finish");
a_postinc_update: assert property (go && mode == `EAC_M_POSTINC |=> reg_write
	&& ea == $past(addr_reg_value) && reg_write_value == ea + size_bytes)
	else $error("postincrement wrong");
a_predec_update: assert property (go && mode == `EAC_M_PREDEC |=> reg_write
	&& ea == $past(addr_reg_value) - size_bytes && reg_write_value == ea)
	else $error("predecrement wrong");
a_size_code: assert property (go |=> size_bytes == 4'h1 << $past(op_size))
	else $error("size in bytes wrong");
a_bcd_packed: assert property (go && data_type == `EAC_DT_BCD_PACK
	&& op_size != `EAC_SZ_QUAD |=> bcd_digits == size_bytes << 1)
	else $error("packed digit count wrong");
a_field_bad: assert property (go && data_type == `EAC_DT_FIELD
	&& (field_width == 6'h00 || field_width > 6'h20) |=> illegal)
	else $error("bad field width accepted");
a_disp_sext: assert property (go && mode == `EAC_M_DISP16
	|=> ea == $past(addr_reg_value) + sd_ext)
	else $error("displacement sum wrong");
a_quad_imm: assert property (go && mode == `EAC_M_IMM
	&& op_size == `EAC_SZ_QUAD |=> illegal)
	else $error("quad immediate not flagged");
c_fetch: cover property (fetch_req && fetch_ack);
c_postinc: cover property (go && mode == `EAC_M_POSTINC);
c_illegal: cover property (done && illegal);
endmodule

bind eac_core eac_core_sva i_eac_core_sva (.*);

// ==== eac_mem_model.sv ====
// Pointer memory answering the indirect fetches
`timescale 1ns/1ps
module eac_mem_model
(
	input  wire        clock,
	input  wire        reset_n,
	input  wire        fetch_req,
	input  wire [31:0] fetch_addr,
	input  wire [3:0]  wait_cycles,
	output reg         fetch_ack,
	output reg  [31:0] fetch_data
);
reg [3:0] cnt;
// Data toggles outside the ack cycle so a stale read never matches
always @(posedge clock or negedge reset_n)
begin
	if (!reset_n)
	begin
		cnt <= 4'h0;
		fetch_ack <= 1'b0;
		fetch_data <= 32'h0000_0000;
	end
	else if (fetch_req && !fetch_ack && cnt == wait_cycles)
	begin
		fetch_ack <= 1'b1;
		fetch_data <= fetch_addr ^ 32'h5a5a_5a5a;
		cnt <= 4'h0;
	end
	else
	begin
		fetch_ack <= 1'b0;
		fetch_data <= ~fetch_data;
		cnt <= (fetch_req && !fetch_ack) ? cnt + 4'h1 : 4'h0;
	end
end
endmodule

// ==== eac_core_test.sv ====
// Self-checking bench for the effective address block
`timescale 1ns/1ps
`include "eac_map.vh"
module eac_core_test;
reg        clock = 0, reset_n = 0, start = 0, index_long = 0;
reg        base_disp_long = 0, base_disp_present = 0;
reg        outer_disp_long = 0, outer_disp_present = 0;
reg [4:0]  mode = 0;
reg [1:0]  op_size = 0, data_type = 0, index_scale = 0;
reg [5:0]  field_width = 6'h01;
reg [3:0]  wait_cycles = 0;
reg [15:0] short_disp = 16'hff80;
reg [31:0] addr_reg_value = 32'h0000_1000, index_reg_value = 32'h0001_fffe;
reg [31:0] pc_value = 32'h0002_0000, ext_value = 32'h1234_5687;
reg [31:0] base_disp = 0, outer_disp = 0, b, fa;
wire       fetch_req, fetch_ack, busy, done, reg_write, illegal, is_immediate, is_register;
wire [31:0] fetch_addr, fetch_data, ea, imm_value, reg_write_value;
wire [3:0] size_bytes, bcd_digits, reg_sel, reg_write_sel;
integer    errors = 0, n_tests = 0, cycles = 0, i, s;
eac_core i_eac_core
(
	.clock(clock), .reset_n(reset_n), .start(start), .mode(mode), .op_size(op_size),
	.data_type(data_type), .field_width(field_width), .addr_reg_sel(4'h3),
	.data_reg_sel(4'h2), .index_reg_sel(4'h5), .index_long(index_long),
	.index_scale(index_scale), .addr_reg_value(addr_reg_value),
	.index_reg_value(index_reg_value), .pc_value(pc_value), .short_disp(short_disp),
	.base_disp(base_disp), .base_disp_long(base_disp_long),
	.base_disp_present(base_disp_present), .outer_disp(outer_disp),
	.outer_disp_long(outer_disp_long), .outer_disp_present(outer_disp_present),
	.ext_value(ext_value), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
	.fetch_ack(fetch_ack), .fetch_data(fetch_data), .busy(busy), .done(done), .ea(ea),
	.imm_value(imm_value), .is_register(is_register), .is_immediate(is_immediate),
	.reg_sel(reg_sel), .reg_write(reg_write), .reg_write_sel(reg_write_sel),
	.reg_write_value(reg_write_value), .size_bytes(size_bytes), .bcd_digits(bcd_digits),
	.illegal(illegal)
);
eac_mem_model i_eac_mem_model (.*);
always #2.5 clock = ~clock;
// ------------------------------------------------------------
// Shared tasks
// ------------------------------------------------------------
task report_and_stop;
begin
	$display("checks %0d mismatches %0d", n_tests, errors);
	if (errors == 0 && n_tests > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
end
endtask
task chk(input [31:0] seen, input [31:0] exp);
begin
	n_tests = n_tests + 1;
	if (seen !== exp)
	begin
		errors = errors + 1;
		$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
	end
end
endtask
// Called at a rising edge; returns at the edge after done, results held
task go(input [4:0] m);
begin
	mode <= m;
	start <= 1'b1;
	@(posedge clock);
	start <= 1'b0;
	i = 0;
	#1;
	while (done !== 1'b1 && i < 20)
	begin
		@(posedge clock);
		#1;
		i = i + 1;
	end
	chk(done, 1);
	@(posedge clock);
end
endtask
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task t_postpre;
begin
	for (s = 0; s < 4; s = s + 1)
	begin
		op_size <= s[1:0];
		go(`EAC_M_POSTINC);
		chk(ea, 32'h0000_1000);
		chk(reg_write_value, 32'h0000_1000 + (1 << s));
		chk(size_bytes, 1 << s);
		chk(reg_write_sel, 4'h3);
		go(`EAC_M_PREDEC);
		chk(ea, 32'h0000_1000 - (1 << s));
		chk(reg_write_value, 32'h0000_1000 - (1 << s));
	end
	$display("postinc and predec done");
end
endtask
task t_disp;
begin
	go(`EAC_M_DISP16);
	chk(ea, 32'h0000_0f80);
	go(`EAC_M_PCDISP16);
	chk(ea, 32'h0001_ff80);
	for (s = 0; s < 4; s = s + 1)
	begin
		index_scale <= s[1:0];
		index_long <= 1'b0;
		go(`EAC_M_IDX8);
		chk(ea, 32'h0000_0f80 - (2 << s));
		index_long <= 1'b1;
		go(`EAC_M_PCIDX8);
		chk(ea, 32'h0001_ff80 + (32'h0001_fffe << s));
	end
	index_scale <= 0;
	base_disp <= 32'h0010_0000;
	base_disp_long <= 1'b1;
	base_disp_present <= 1'b1;
	go(`EAC_M_IDXBD);
	chk(ea, 32'h0012_0ffe);
	go(`EAC_M_PCIDXBD);
	chk(ea, 32'h0013_fffe);
	$display("displacement and index done");
end
endtask
task t_mem;
begin
	base_disp <= 32'h0000_8004;
	base_disp_long <= 1'b0;
	outer_disp <= 32'h0000_fff0;
	outer_disp_present <= 1'b1;
	index_long <= 1'b0;
	index_scale <= 1;
	for (s = 0; s < 4; s = s + 1)
	begin
		wait_cycles <= s[3:0];
		b = s[1] ? pc_value : addr_reg_value;
		go(s[1] ? (s[0] ? `EAC_M_PCMEMPRE : `EAC_M_PCMEMPOST)
			: (s[0] ? `EAC_M_MEMPRE : `EAC_M_MEMPOST));
		fa = b + 32'hffff_8004 - (s[0] ? 32'h4 : 32'h0);
		chk(fetch_addr, fa);
		chk(ea, (fa ^ 32'h5a5a_5a5a) - (s[0] ? 32'h0 : 32'h4) - 32'h10);
	end
	$display("memory indirect done");
end
endtask
task t_types;
begin
	data_type <= `EAC_DT_FIELD;
	for (s = 0; s < 4; s = s + 1)
	begin
		field_width <= (s == 0) ? 6'h01 : (s == 1) ? 6'h20 : (s == 2) ? 6'h00 : 6'h21;
		go(`EAC_M_IND);
		chk(illegal, s > 1);
	end
	op_size <= `EAC_SZ_WORD;
	data_type <= `EAC_DT_BCD_PACK;
	go(`EAC_M_IND);
	chk(bcd_digits, 4);
	data_type <= `EAC_DT_BCD_UNPK;
	go(`EAC_M_IND);
	chk(bcd_digits, 2);
	data_type <= `EAC_DT_INT;
	for (s = 0; s < 3; s = s + 1)
	begin
		op_size <= s[1:0];
		go(`EAC_M_IMM);
		chk(imm_value, (s == 0) ? 32'h87 : (s == 1) ? 32'h5687 : ext_value);
		chk(is_immediate, 1);
	end
	$display("types and immediates done");
end
endtask
task t_direct;
begin
	go(`EAC_M_DREG);
	chk(is_register, 1);
	chk(reg_sel, 4'h2);
	go(`EAC_M_AREG);
	chk(is_register, 1);
	chk(reg_sel, 4'h3);
	go(`EAC_M_ABSW);
	chk(is_register, 0);
	chk(ea, 32'hffff_ff80);
	go(`EAC_M_ABSL);
	chk(ea, 32'h1234_5687);
	op_size <= `EAC_SZ_QUAD;
	go(`EAC_M_IMM);
	chk(is_immediate, 1);
	chk(illegal, 1);
	go(5'h1f);
	chk(illegal, 1);
	$display("direct, absolute and illegal done");
end
endtask
// Reset lands while a pointer fetch is still waiting
task t_reset;
begin
	wait_cycles <= 4'hf;
	mode <= `EAC_M_MEMPOST;
	start <= 1'b1;
	@(posedge clock);
	start <= 1'b0;
	repeat (3) @(posedge clock);
	chk(fetch_req, 1);
	reset_n <= 1'b0;
	#1;
	chk(busy, 0);
	chk(fetch_req, 0);
	chk(fetch_addr, 32'h0000_0000);
	chk(ea, 32'h0000_0000);
	@(posedge clock);
	reset_n <= 1'b1;
	@(posedge clock);
	wait_cycles <= 4'h0;
	go(`EAC_M_IND);
	chk(ea, 32'h0000_1000);
	$display("reset in mid-fetch done");
end
endtask
always @(posedge clock)
begin
	cycles = cycles + 1;
	if (cycles == 3000)
	begin
		errors = errors + 1;
		report_and_stop;
	end
end
initial
begin
	repeat (6) @(posedge clock);
	reset_n <= 1'b1;
	@(posedge clock);
	t_postpre;
	t_disp;
	t_mem;
	t_types;
	t_direct;
	t_reset;
	report_and_stop;
end
endmodule
